// ### common/eid_params.svh
// offsets, field positions, reset values and counts of the edge-detect controller
`ifndef EID_PARAMS_SVH
`define EID_PARAMS_SVH
// register offsets (byte addresses, one word each)
`define EID_OFF_CMD   8'h00
`define EID_OFF_NF    8'h04
`define EID_OFF_STAT  8'h08
`define EID_OFF_IST   8'h0c
`define EID_OFF_ICLR  8'h10
`define EID_OFF_IEN   8'h14
// field positions
`define EID_CMD_GO_BIT 8
`define EID_NF_GO_BIT  4
`define EID_NF_DMA_BIT 3
// event bit positions in status, clear and enable registers
`define EID_EV_DONE   0
`define EID_EV_NFRDY  1
`define EID_EV_REJ    2
`define EID_EV_W      3
// reset values
`define EID_PMODE_RST 10'h3ff
`define EID_EDGE_RST  2'h0
`define EID_NFC_RST   3'h0
// pin indices and counts
`define EID_NPINS     10
`define EID_PIN_IRQ7  4'h8
`define EID_PIN_IRQ8  4'h9
`define EID_NF_TICKS  2'h3
// cycles from a sampling clock pin edge to its tick count: three sync flops, agree, edge
`define EID_NF_GUARD  3'h5
`endif

// ### common/eid_pkg.sv
// types shared by the edge-detect controller modules
package eid_pkg;
	// how a pin is to be used
	typedef enum logic [1:0] {USE_PORT, USE_IRQ, USE_SERIAL, USE_RSVD} eid_use_e;
	// edge-select pair: a = falling, b = rising; 00 means no detection
	typedef struct packed {
		logic a;
		logic b;
	} eid_edge_s;
	// one pin reconfiguration order
	typedef struct packed {
		eid_use_e  pin_use;
		eid_edge_s edge_sel;
		logic [3:0] pin;
	} eid_cmd_s;
	// one noise filter clock change order
	typedef struct packed {
		logic       dma;
		logic [2:0] sel;
	} eid_nf_s;
	// sequencer states
	typedef enum {ST_IDLE, ST_EDGE_OFF, ST_RX_OFF, ST_MODE, ST_RX_ON, ST_EDGE_ON,
		ST_NF_SET, ST_NF_WAIT, ST_NF_CLR, ST_NF_EN} eid_state_e;
endpackage

// ### core/eid_sync3.sv
// three-flop pin synchroniser, output moves once stages two and three agree
`timescale 1ns/100ps
module eid_sync3
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// pin in, clean level out
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// stage one feeds stage two only
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			s1_reg    <= 1'b0;
			s2_reg    <= 1'b0;
			s3_reg    <= 1'b0;
			level_out <= 1'b0;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_out <= s3_reg; // a one-sample glitch never passes
		end
	end
endmodule // eid_sync3

// ### core/eid_apb_regs.sv
// apb slave: order registers, status and the sticky event interrupt
`timescale 1ns/100ps
`include "eid_params.svh"
module eid_apb_regs
(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          reset,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// orders to the sequencer
	output logic               cmd_go,
	output eid_pkg::eid_cmd_s  cmd,
	output logic               nf_go,
	output eid_pkg::eid_nf_s   nf,
	// sequencer state and events
	input  wire logic          busy,
	input  wire logic [1:0]    tick_cnt,
	input  wire logic [`EID_EV_W-1:0] ev,
	output logic               irq
);
	import eid_pkg::*;

	logic [`EID_EV_W-1:0] ist_reg;
	logic [`EID_EV_W-1:0] ien_reg;
	logic                 wr;
	logic                 mapped;

	// zero-wait slave: access phase always completes
	assign pready  = 1'b1;
	assign wr      = psel && penable && pwrite;
	assign mapped  = paddr <= `EID_OFF_IEN && paddr[1:0] == 2'h0;
	assign pslverr = psel && penable && !mapped;
	assign cmd_go  = wr && paddr == `EID_OFF_CMD && pwdata[`EID_CMD_GO_BIT];
	assign nf_go   = wr && paddr == `EID_OFF_NF && pwdata[`EID_NF_GO_BIT];
	assign irq     = |(ist_reg & ien_reg);

	// order fields are kept so software can read them back
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			cmd     <= '0;
			nf      <= '0;
			ien_reg <= '0;
		end
		else
		begin
			if (wr && paddr == `EID_OFF_CMD)
				cmd <= pwdata[7:0];
			if (wr && paddr == `EID_OFF_NF)
				nf <= pwdata[3:0];
			if (wr && paddr == `EID_OFF_IEN)
				ien_reg <= pwdata[`EID_EV_W-1:0];
		end
	end

	// sticky events: a new event beats a clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			ist_reg <= '0;
		else if (wr && paddr == `EID_OFF_ICLR)
			ist_reg <= (ist_reg & ~pwdata[`EID_EV_W-1:0]) | ev;
		else
			ist_reg <= ist_reg | ev;
	end

	// read data registered in the setup cycle, valid through the access phase
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			prdata <= '0;
		else if (psel && !penable)
		begin
			case (paddr)
				`EID_OFF_CMD:  prdata <= {24'h0, cmd};
				`EID_OFF_NF:   prdata <= {28'h0, nf};
				`EID_OFF_STAT: prdata <= {29'h0, tick_cnt, busy};
				`EID_OFF_IST:  prdata <= {29'h0, ist_reg};
				`EID_OFF_IEN:  prdata <= {29'h0, ien_reg};
				default:       prdata <= '0;
			endcase
		end
	end
endmodule // eid_apb_regs

// ### core/eid_ctrl.sv
// controller that reconfigures external interrupt pins of the device safely
// Function
// RULE1 - clear edge pair before selecting port mode
// RULE2 - unused port-0 pairs held at 00
// RULE3 - irq7 pair cleared before port mode
// RULE4 - irq7 pair 00 while pin is serial0 receive
// RULE5 - serial0 receive off while pin is irq7
// RULE6 - irq7 pair 00 unless used as interrupt
// RULE7 - irq8 pair cleared before port mode
// RULE8 - irq8 and serial3 receive used exclusively
// RULE9 - irq8 pair 00 unless used as interrupt
// RULE10 - port-9 pairs cleared first, 00 when unused
// RULE11 - filter needs 3 sampling clocks after change
// RULE12 - wait 3 clocks, clear flag, then enable
// RULE13 - dma enabled only after 3 sampling clocks
// RULE14 - after reset nmi pin is port, no edge
// RULE15 - pair 00 off, else falling, rising, both
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "eid_params.svh"
module eid_ctrl
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// edge-select pairs to the device
	output logic [4:0]       port0_edge_sel_a,
	output logic [4:0]       port0_edge_sel_b,
	output logic [2:0]       port9_edge_sel_a,
	output logic [2:0]       port9_edge_sel_b,
	output logic             irq7_edge_sel_a,
	output logic             irq7_edge_sel_b,
	output logic             irq8_edge_sel_a,
	output logic             irq8_edge_sel_b,
	// port or alternate function, one bit per pin, 1 = port
	output logic [9:0]       pin_port_mode,
	// serial receive enables
	output logic             serial0_rx_enable,
	output logic             serial3_rx_enable,
	// noise filter and irq3 handling
	output logic [2:0]       noise_filter_ctrl,
	input  wire logic        nf_sample_clk_pin,
	output logic             irq3_flag_clear,
	output logic             irq3_int_enable,
	output logic             irq3_dma_enable,
	// interrupt to software
	output logic             irq
);
	import eid_pkg::*;

	eid_state_e          state_reg;
	eid_cmd_s            cur_reg;
	eid_cmd_s            cmd_wr;
	eid_nf_s             nf;
	logic                cmd_go;
	logic                nf_go;
	logic                cmd_ok;
	logic                take_cmd;
	logic [`EID_EV_W-1:0] ev;
	eid_edge_s           edge_reg [`EID_NPINS];
	logic [9:0]          edge_nz;
	logic                smp_lvl;
	logic                smp_prev_reg;
	logic                tick;
	logic [1:0]          tick_cnt_reg;
	logic                nf_dma_reg;
	logic [2:0]          guard_reg;

	// only irq7 and irq8 pins share a serial receive line
	function automatic logic is_shared(input logic [3:0] p);
		return p == `EID_PIN_IRQ7 || p == `EID_PIN_IRQ8;
	endfunction

	// a pin index names one of the ten controlled pins
	function automatic logic pin_ok(input logic [3:0] p);
		return p < 4'ha;
	endfunction

	eid_apb_regs u_regs
	(
		.sys_clk  (sys_clk),
		.reset    (reset),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.cmd_go   (cmd_go),
		.cmd      (),
		.nf_go    (nf_go),
		.nf       (nf),
		.busy     (state_reg != ST_IDLE),
		.tick_cnt (tick_cnt_reg),
		.ev       (ev),
		.irq      (irq)
	);

	// the sampling clock is a device pin, far too slow to be a clock here
	eid_sync3 u_smp
	(
		.sys_clk   (sys_clk),
		.reset     (reset),
		.pin_in    (nf_sample_clk_pin),
		.level_out (smp_lvl)
	);

	// sampling clock tick on the clean rising edge
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			smp_prev_reg <= 1'b0;
		else
			smp_prev_reg <= smp_lvl;
	end
	assign tick = smp_lvl && !smp_prev_reg;

	// orders: serial use only on shared pins; a busy sequencer refuses
	// the stored order only lands at the go edge, so judge and capture the bus word itself
	assign cmd_wr   = pwdata[7:0];
	assign cmd_ok   = pin_ok(cmd_wr.pin) && cmd_wr.pin_use != USE_RSVD &&
		(cmd_wr.pin_use != USE_SERIAL || is_shared(cmd_wr.pin));
	assign take_cmd = cmd_go && state_reg == ST_IDLE && !nf_go && cmd_ok;
	assign ev[`EID_EV_DONE]  = state_reg == ST_EDGE_ON;
	assign ev[`EID_EV_NFRDY] = state_reg == ST_NF_EN;
	assign ev[`EID_EV_REJ]   = (cmd_go && !take_cmd && !(nf_go && state_reg == ST_IDLE)) ||
		(nf_go && state_reg != ST_IDLE) || (cmd_go && nf_go && state_reg == ST_IDLE);

	// sequencer: edges off, receive off, mode, receive on, edges on
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			state_reg <= ST_IDLE;
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (nf_go)
						state_reg <= ST_NF_SET;
					else if (take_cmd)
						state_reg <= ST_EDGE_OFF;
				end
				ST_EDGE_OFF: state_reg <= ST_RX_OFF;
				ST_RX_OFF:   state_reg <= ST_MODE;
				ST_MODE:     state_reg <= ST_RX_ON;
				ST_RX_ON:    state_reg <= ST_EDGE_ON;
				ST_EDGE_ON:  state_reg <= ST_IDLE;
				ST_NF_SET:   state_reg <= ST_NF_WAIT;
				ST_NF_WAIT:
				begin
					if (tick_cnt_reg == `EID_NF_TICKS) // [RULE11] [RULE12]
						state_reg <= ST_NF_CLR;
				end
				ST_NF_CLR:   state_reg <= ST_NF_EN;
				ST_NF_EN:    state_reg <= ST_IDLE;
				default:     state_reg <= ST_IDLE;
			endcase
		end
	end

	// order captured once, so a rewrite mid-sequence cannot tear it
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			cur_reg <= '0;
		else if (take_cmd)
			cur_reg <= cmd_wr;
	end

	// edge pairs: cleared first, set last and only for interrupt use
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < `EID_NPINS; i++)
				edge_reg[i] <= `EID_EDGE_RST; // [RULE14]
		end
		else if (state_reg == ST_EDGE_OFF)
			edge_reg[cur_reg.pin] <= `EID_EDGE_RST; // [RULE1] [RULE3] [RULE7] [RULE10]
		else if (state_reg == ST_EDGE_ON && cur_reg.pin_use == USE_IRQ)
			edge_reg[cur_reg.pin] <= cur_reg.edge_sel; // [RULE15] [RULE2] [RULE6] [RULE9]
	end

	// port mode changes only while the pin's pair is 00
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			pin_port_mode <= `EID_PMODE_RST; // [RULE14]
		else if (state_reg == ST_MODE)
			pin_port_mode[cur_reg.pin] <= cur_reg.pin_use == USE_PORT; // [RULE1]
	end

	// shared pins: receive off before the pin becomes anything else
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			serial0_rx_enable <= 1'b0;
			serial3_rx_enable <= 1'b0;
		end
		else if (state_reg == ST_RX_OFF && cur_reg.pin_use != USE_SERIAL)
		begin
			if (cur_reg.pin == `EID_PIN_IRQ7)
				serial0_rx_enable <= 1'b0; // [RULE5]
			if (cur_reg.pin == `EID_PIN_IRQ8)
				serial3_rx_enable <= 1'b0; // [RULE8]
		end
		else if (state_reg == ST_RX_ON && cur_reg.pin_use == USE_SERIAL)
		begin
			if (cur_reg.pin == `EID_PIN_IRQ7)
				serial0_rx_enable <= 1'b1; // [RULE4]
			if (cur_reg.pin == `EID_PIN_IRQ8)
				serial3_rx_enable <= 1'b1; // [RULE8]
		end
	end

	// filter change: request paths off until the filter has settled
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			noise_filter_ctrl <= `EID_NFC_RST;
			nf_dma_reg        <= 1'b0;
			irq3_int_enable   <= 1'b0;
			irq3_dma_enable   <= 1'b0;
		end
		else if (state_reg == ST_NF_SET)
		begin
			noise_filter_ctrl <= nf.sel;
			nf_dma_reg        <= nf.dma;
			irq3_int_enable   <= 1'b0; // [RULE12]
			irq3_dma_enable   <= 1'b0; // [RULE13]
		end
		else if (state_reg == ST_NF_EN)
		begin
			irq3_int_enable <= 1'b1; // [RULE12]
			irq3_dma_enable <= nf_dma_reg; // [RULE13]
		end
	end

	// flag clear pulse between settling and enabling
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			irq3_flag_clear <= 1'b0;
		else
			irq3_flag_clear <= state_reg == ST_NF_CLR; // [RULE12]
	end

	// count sampling clocks after the change, saturating
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			tick_cnt_reg <= '0;
		else if (state_reg == ST_NF_SET)
			tick_cnt_reg <= '0;
		else if (state_reg == ST_NF_WAIT && tick && guard_reg == `EID_NF_GUARD &&
			tick_cnt_reg != `EID_NF_TICKS)
			tick_cnt_reg <= tick_cnt_reg + 2'h1; // [RULE11]
	end

	// ticks still inside the synchroniser left the pin before the change, so skip them
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			guard_reg <= '0;
		else if (state_reg == ST_NF_SET)
			guard_reg <= '0;
		else if (state_reg == ST_NF_WAIT && guard_reg != `EID_NF_GUARD)
			guard_reg <= guard_reg + 3'h1; // [RULE11]
	end

	// pairs out to the device registers
	always_comb
	begin
		for (int i = 0; i < 5; i++)
		begin
			port0_edge_sel_a[i] = edge_reg[i].a;
			port0_edge_sel_b[i] = edge_reg[i].b;
		end
		for (int i = 0; i < 3; i++)
		begin
			port9_edge_sel_a[i] = edge_reg[i+5].a;
			port9_edge_sel_b[i] = edge_reg[i+5].b;
		end
		irq7_edge_sel_a = edge_reg[8].a;
		irq7_edge_sel_b = edge_reg[8].b;
		irq8_edge_sel_a = edge_reg[9].a;
		irq8_edge_sel_b = edge_reg[9].b;
		for (int i = 0; i < `EID_NPINS; i++)
			edge_nz[i] = edge_reg[i].a || edge_reg[i].b;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// no pin is in port mode with detection armed
	a_port_edge_off: assert property ((pin_port_mode & edge_nz) == 10'h0) // [RULE1] [RULE3] [RULE7] [RULE10]
		else $error("port-mode pin has edge detection on");
	// serial receive and irq edge never coexist on a shared pin
	a_shared_excl: assert property ( // [RULE4] [RULE5] [RULE8]
		!(serial0_rx_enable && edge_nz[8]) && !(serial3_rx_enable && edge_nz[9]))
		else $error("shared pin used as receive and interrupt");
	// pairs of non-interrupt pins go to 00 on completion
	a_unused_zero: assert property ( // [RULE2] [RULE6] [RULE9]
		state_reg == ST_EDGE_ON && cur_reg.pin_use != USE_IRQ |=> !edge_nz[cur_reg.pin])
		else $error("unused pin pair not 00");
	// interrupt use applies the ordered pair exactly
	a_edge_apply: assert property ( // [RULE15]
		state_reg == ST_EDGE_ON && cur_reg.pin_use == USE_IRQ |=>
		edge_reg[$past(cur_reg.pin)] == $past(cur_reg.edge_sel))
		else $error("edge pair not applied");
	// flag clear only after three sampling clocks
	a_nf_settle: assert property ( // [RULE11]
		$rose(irq3_flag_clear) |-> tick_cnt_reg == `EID_NF_TICKS && $past(state_reg, 2) == ST_NF_WAIT)
		else $error("flag cleared before filter settled");
	// interrupt enable follows the flag clear by one cycle
	a_nf_order: assert property ( // [RULE12]
		$rose(irq3_int_enable) |-> $past(irq3_flag_clear) && tick_cnt_reg == `EID_NF_TICKS)
		else $error("irq3 enabled without settle and clear");
	// dma stays off during settling and starts only afterwards
	a_nf_dma: assert property (state_reg == ST_NF_WAIT |-> !irq3_dma_enable && !irq3_int_enable) // [RULE13]
		else $error("irq3 path enabled during settling");
	// reset leaves the nmi pin a port pin without detection
	a_reset_nmi: assert property ($past(reset) |-> pin_port_mode[0] && !edge_nz[0]) // [RULE14]
		else $error("nmi pin not port after reset");
endmodule // eid_ctrl

// ### tb/eid_dev_model.sv
// behavioural model of the device's edge detectors and pin noise filter
`timescale 1ns/100ps
module eid_dev_model
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// controller outputs
	input  wire logic [9:0] fall_sel,
	input  wire logic [9:0] rise_sel,
	input  wire logic [9:0] port_mode,
	input  wire logic [1:0] rx_en,
	input  wire logic [2:0] nf_sel,
	input  wire logic       flag3_clr,
	input  wire logic       int3_en,
	input  wire logic       dma3_en,
	// signal sources and bench
	input  wire logic [9:0] pin_lvl,
	input  wire logic       flags_clr,
	// sampling clock, request flags, fault count
	output logic            nf_clk,
	output logic [9:0]      req_flag,
	output logic [7:0]      fault_cnt
);
	logic [9:0] det_q;
	logic [9:0] lvl;
	logic [3:0] div_cnt;
	logic [2:0] sel_q;
	logic [1:0] init_cnt;
	logic       clk_q;
	logic       en_q;
	logic       dma_q;
	logic       bad;
	assign lvl = pin_lvl & ~port_mode;
	// sampling clock runs free, half period of sel+2 cycles
	always_ff @(posedge sys_clk)
	begin
		div_cnt <= (reset || div_cnt >= {1'b0, nf_sel} + 4'h1) ? 4'h0 : div_cnt + 4'h1;
		nf_clk  <= reset ? 1'b0 : nf_clk ^ (div_cnt >= {1'b0, nf_sel} + 4'h1);
		clk_q   <= nf_clk;
		sel_q   <= nf_sel;
	end
	// filter restarts on a selection change and settles after three ticks
	always_ff @(posedge sys_clk)
		if (reset)
			init_cnt <= 2'h3;
		else if (sel_q != nf_sel)
			init_cnt <= 2'h0;
		else if (nf_clk && !clk_q && init_cnt != 2'h3)
			init_cnt <= init_cnt + 2'h1;
	// enabled edges of alternate-function pins set flags; pairs at 00 detect nothing
	always_ff @(posedge sys_clk)
		if (reset)
		begin
			det_q    <= 10'h000;
			req_flag <= 10'h000;
		end
		else
		begin
			det_q    <= lvl;
			req_flag <= (flags_clr ? 10'h000 : req_flag) | (det_q & ~lvl & fall_sel) | (~det_q & lvl & rise_sel);
			if (flag3_clr)
				req_flag[4] <= 1'b0;
			if (nf_clk && !clk_q && init_cnt != 2'h3)
				req_flag[4] <= 1'b1; // unsettled filter lets a request through
		end
	// any controller action that could latch a false request is counted
	assign bad = (|((fall_sel | rise_sel) & port_mode))
		|| (rx_en[0] && (fall_sel[8] || rise_sel[8])) || (rx_en[1] && (fall_sel[9] || rise_sel[9]))
		|| (int3_en && !en_q && (req_flag[4] || init_cnt != 2'h3))
		|| (dma3_en && !dma_q && init_cnt != 2'h3);
	always_ff @(posedge sys_clk)
	begin
		en_q      <= int3_en;
		dma_q     <= dma3_en;
		fault_cnt <= reset ? 8'h00 : fault_cnt + {7'h0, bad};
	end
endmodule // eid_dev_model

// ### tb/testbench.sv
// self-checking bench for the edge-detect controller and the device model
`timescale 1ns/100ps
`include "eid_params.svh"
module testbench;
	import eid_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, nf_clk, flag3_clr, int3_en, dma3_en;
	logic [4:0]  p0_a, p0_b;
	logic [2:0]  p9_a, p9_b, nf_sel;
	logic        i7_a, i7_b, i8_a, i8_b, rx0, rx3;
	logic [9:0]  port_mode, req_flag, pin_lvl;
	logic        flags_clr = 1'b0;
	logic [7:0]  fault_cnt;
	logic [2:0]  ien = 3'h3;
	int          err_count = 0;
	int          checked = 0;
	int          cycles = 0;
	wire  [9:0]  fall_sel = {i8_a, i7_a, p9_a, p0_a};
	wire  [9:0]  rise_sel = {i8_b, i7_b, p9_b, p0_b};

	always #2 sys_clk = ~sys_clk;

	eid_ctrl dut
	(
		.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port0_edge_sel_a(p0_a), .port0_edge_sel_b(p0_b), .port9_edge_sel_a(p9_a), .port9_edge_sel_b(p9_b),
		.irq7_edge_sel_a(i7_a), .irq7_edge_sel_b(i7_b), .irq8_edge_sel_a(i8_a), .irq8_edge_sel_b(i8_b),
		.pin_port_mode(port_mode), .serial0_rx_enable(rx0), .serial3_rx_enable(rx3),
		.noise_filter_ctrl(nf_sel), .nf_sample_clk_pin(nf_clk), .irq3_flag_clear(flag3_clr),
		.irq3_int_enable(int3_en), .irq3_dma_enable(dma3_en), .irq(irq)
	);

	eid_dev_model device
	(
		.sys_clk(sys_clk), .reset(reset), .fall_sel(fall_sel), .rise_sel(rise_sel), .port_mode(port_mode),
		.rx_en({rx3, rx0}), .nf_sel(nf_sel), .flag3_clr(flag3_clr), .int3_en(int3_en), .dma3_en(dma3_en),
		.pin_lvl(pin_lvl), .flags_clr(flags_clr), .nf_clk(nf_clk), .req_flag(req_flag), .fault_cnt(fault_cnt)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one apb transfer; ends at a falling edge so outputs are settled for checks
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// access phase lasts until the slave answers; only the bench timeout ends a hang
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk(er, 1'(a > `EID_OFF_IEN || a[1:0] != 2'h0), "slave error");
		@(negedge sys_clk);
	endtask

	// poll an event bit, check the interrupt line, then clear the bit
	task automatic wait_clr(input int b);
		logic [31:0] rd;
		logic        er;
		rd = 32'h0;
		for (int k = 0; k < 60 && rd[b] !== 1'b1; k++)
			apb(1'b0, `EID_OFF_IST, 32'h0, rd, er);
		chk(rd[b], 1'b1, "event seen");
		chk(irq, |(rd[2:0] & ien), "irq raised or masked");
		apb(1'b1, `EID_OFF_ICLR, 32'h1 << b, rd, er);
		apb(1'b0, `EID_OFF_IST, 32'h0, rd, er);
		chk({rd[b], irq}, {1'b0, |(rd[2:0] & ien)}, "event cleared");
	endtask

	task automatic order(input logic [7:0] off, input logic [31:0] w, input int b);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, off, w, rd, er);
		wait_clr(b);
	endtask

	function automatic logic [31:0] cmd_word(input logic [3:0] p, input logic [1:0] e, input logic [1:0] u);
		return {23'h0, 1'b1, u, e, p};
	endfunction

	// move one pin level and check which request flags it raised
	task automatic pin_step(input logic [3:0] p, input logic v, input logic x);
		@(posedge sys_clk);
		flags_clr  <= 1'b1;
		pin_lvl[p] <= v;
		@(posedge sys_clk);
		flags_clr  <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(req_flag, 10'(x) << p, "edge flags");
	endtask

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			end_sim();
		end
	end

	initial
	begin
		logic [31:0] rd;
		logic        er;
		logic [3:0]  pin;
		logic [1:0]  e;
		logic        dm;
		void'($urandom(42058));
		pin_lvl = 10'($urandom);
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		chk({fall_sel | rise_sel, port_mode}, {10'h0, 10'h3ff}, "reset state");
		apb(1'b0, 8'h40, 32'h0, rd, er);
		chk({rd, er}, {32'h0, 1'b1}, "unmapped");
		apb(1'b1, `EID_OFF_IEN, {29'h0, ien}, rd, er);
		apb(1'b0, `EID_OFF_IEN, 32'h0, rd, er);
		chk(rd, {29'h0, ien}, "enable readback");
		// every pin and edge code, then random picks; odd passes go back to port
		for (int n = 0; n < 16; n++)
		begin
			pin = (n < 10) ? 4'(n) : 4'($urandom_range(9));
			e = (n < 10) ? 2'(n % 3 + 1) : 2'($urandom_range(3, 1));
			order(`EID_OFF_CMD, cmd_word(pin, e, USE_IRQ), 0);
			chk({fall_sel[pin], rise_sel[pin], port_mode[pin], rx3, rx0}, {e, 3'b000}, "irq setup");
			pin_step(pin, 1'b1, e[0] & ~pin_lvl[pin]);
			pin_step(pin, 1'b0, e[1]);
			pin_step(pin, 1'b1, e[0]);
			if (n % 2)
			begin
				order(`EID_OFF_CMD, cmd_word(pin, 2'b11, USE_PORT), 0);
				chk({fall_sel[pin], rise_sel[pin], port_mode[pin]}, 3'b001, "to port");
			end
		end
		// shared pins as receive lines, then taken back as interrupt inputs
		for (int n = 8; n < 10; n++)
		begin
			order(`EID_OFF_CMD, cmd_word(4'(n), 2'b11, USE_SERIAL), 0);
			chk({fall_sel[n], rise_sel[n], port_mode[n], rx3, rx0}, {3'b000, 2'(n - 7)}, "serial");
			order(`EID_OFF_CMD, cmd_word(4'(n), 2'b10, USE_IRQ), 0);
			chk({rx3, rx0, port_mode[n]}, 3'b000, "irq again");
		end
		order(`EID_OFF_CMD, cmd_word(4'h2, 2'b01, USE_RSVD), 2);
		order(`EID_OFF_CMD, cmd_word(4'h2, 2'b01, USE_SERIAL), 2);
		order(`EID_OFF_CMD, cmd_word(4'hc, 2'b01, USE_IRQ), 2);
		// a second order while busy is refused, the first still completes
		for (int n = 0; n < 2; n++)
		begin
			apb(1'b1, `EID_OFF_CMD, cmd_word(4'h5, 2'b01, USE_IRQ), rd, er);
			apb(1'b1, n ? `EID_OFF_NF : `EID_OFF_CMD, n ? 32'h10 : cmd_word(4'h6, 2'b01, USE_IRQ), rd, er);
			wait_clr(0);
			wait_clr(2);
		end
		// every sampling clock selection, enables only after the filter settles
		for (int n = 0; n < 8; n++)
		begin
			dm = 1'($urandom);
			order(`EID_OFF_NF, {27'h0, 1'b1, dm, 3'(7 - n)}, 1);
			chk({nf_sel, int3_en, dma3_en}, {3'(7 - n), 1'b1, dm}, "filter restart");
			apb(1'b0, `EID_OFF_STAT, 32'h0, rd, er);
			chk(rd, {29'h0, `EID_NF_TICKS, 1'b0}, "settle count");
		end
		chk(fault_cnt, 8'h00, "unsafe sequence");
		end_sim();
	end
endmodule // testbench
